//--- pkg/macst_pkg.sv
// shared constants and event carriers for the mac error statistics counters
package macst_pkg;

  // register byte offsets inside the io / memory windows
  localparam logic [7:0] MACST_OFF_LEN_MISMATCH = 8'hCA;
  localparam logic [7:0] MACST_OFF_TX_OK        = 8'hDC;
  localparam logic [7:0] MACST_OFF_OVERSIZE     = 8'hEC;
  localparam logic [7:0] MACST_OFF_LATE_COL     = 8'hF0;

  // counter widths
  localparam int unsigned MACST_W_WIDE   = 32;
  localparam int unsigned MACST_W_NARROW = 16;

  // reset values
  localparam logic [31:0] MACST_RST_WIDE   = 32'h00000000;
  localparam logic [15:0] MACST_RST_NARROW = 16'h0000;

  // thresholds that raise the statistics-update flag
  localparam logic [31:0] MACST_THR_WIDE   = 32'hC0000000;
  localparam logic [15:0] MACST_THR_NARROW = 16'hC000;

  // bit positions inside the statistics mask
  localparam int unsigned MACST_MSK_TX_OK        = 0;
  localparam int unsigned MACST_MSK_OVERSIZE     = 1;
  localparam int unsigned MACST_MSK_LEN_MISMATCH = 2;
  localparam int unsigned MACST_MSK_LATE_COL     = 3;
  localparam int unsigned MACST_MSK_W            = 16;

  // frame size limits in octets
  localparam logic [15:0] MACST_MIN_UNPADDED = 16'h002E;
  localparam logic [15:0] MACST_MAX_CLIENT   = 16'h05DC;
  localparam logic [15:0] MACST_SLOT_OCTETS  = 16'h0040;

  // transmit side events from the mac
  typedef struct packed {
    logic        frame_ok;   // pulse: a frame finished transmitting successfully
    logic        collision;  // pulse: a collision was seen
    logic [15:0] octet_pos;  // octets sent in the current frame at the collision
  } macst_tx_evt_t;

  // receive side events from the mac
  typedef struct packed {
    logic        frame_done;  // pulse: a received frame ended
    logic [15:0] frame_len;   // total frame length in octets
    logic [15:0] type_len;    // length/type field value
    logic [15:0] data_octets; // client data octets actually received
  } macst_rx_evt_t;

endpackage

//--- rtl/macst_err_stats.sv
// transmit ok, oversize, length mismatch and late collision statistics counters
`timescale 1ns/1ps

module macst_err_stats
  import macst_pkg::*;
#(
  parameter logic [15:0] MIN_UNPADDED = MACST_MIN_UNPADDED,
  parameter logic [15:0] MAX_CLIENT   = MACST_MAX_CLIENT,
  parameter logic [15:0] SLOT_OCTETS  = MACST_SLOT_OCTETS
) (
  input  logic                  ref_clk_i,
  input  logic                  srst_i,
  input  logic                  stats_global_on_i,
  input  logic [MACST_MSK_W-1:0] stats_mask_reg_i,
  input  logic [15:0]           max_frame_length_reg_i,
  input  macst_tx_evt_t         tx_evt_i,
  input  macst_rx_evt_t         rx_evt_i,
  input  logic [7:0]            reg_addr_i,
  input  logic                  reg_wr_i,
  input  logic [31:0]           reg_wdata_i,
  input  logic                  reg_rd_i,
  output logic [31:0]           reg_rdata_o,
  output logic                  reg_rvalid_o,
  input  logic                  stats_flag_clr_i,
  output logic                  stats_threshold_flag_o
);

  // refuse limits that make the in-range window empty or the slot size zero
  if (MIN_UNPADDED > MAX_CLIENT || SLOT_OCTETS == 16'h0000) begin : g_bad_limits
    $error("macst_err_stats: MIN_UNPADDED above MAX_CLIENT or zero slot");
  end

  logic        on_tx_ok;
  logic        on_oversize;
  logic        on_mismatch;
  logic        on_late;
  logic        evt_oversize;
  logic        evt_in_range;
  logic        evt_short;
  logic        evt_late;
  logic        inc_tx_ok;
  logic        inc_oversize;
  logic        inc_mismatch;
  logic        inc_late;
  logic        wr_tx_ok;
  logic        wr_oversize;
  logic        wr_mismatch;
  logic        wr_late;
  logic [31:0] cnt_tx_ok;
  logic [15:0] cnt_oversize;
  logic [15:0] cnt_mismatch;
  logic [31:0] cnt_late;
  logic        hit_tx_ok;
  logic        hit_oversize;
  logic        hit_mismatch;
  logic        hit_late;
  logic        any_hit;

  // per-counter enables from the global switch and the mask
  assign on_tx_ok    = stats_global_on_i & ~stats_mask_reg_i[MACST_MSK_TX_OK];
  assign on_oversize = stats_global_on_i & ~stats_mask_reg_i[MACST_MSK_OVERSIZE];
  assign on_mismatch = stats_global_on_i & ~stats_mask_reg_i[MACST_MSK_LEN_MISMATCH];
  assign on_late     = stats_global_on_i & ~stats_mask_reg_i[MACST_MSK_LATE_COL];

  // frame event classification
  assign evt_oversize = rx_evt_i.frame_done
                      & (rx_evt_i.frame_len > max_frame_length_reg_i);
  assign evt_in_range = (rx_evt_i.type_len >= MIN_UNPADDED)
                      & (rx_evt_i.type_len <= MAX_CLIENT)
                      & (rx_evt_i.type_len != rx_evt_i.data_octets);
  assign evt_short    = (rx_evt_i.type_len < MIN_UNPADDED)
                      & (rx_evt_i.data_octets > MIN_UNPADDED);
  assign evt_late     = tx_evt_i.collision & (tx_evt_i.octet_pos > SLOT_OCTETS);

  // qualified increments
  assign inc_tx_ok    = tx_evt_i.frame_ok & on_tx_ok;
  assign inc_oversize = evt_oversize & on_oversize;
  assign inc_mismatch = rx_evt_i.frame_done & (evt_in_range | evt_short) & on_mismatch;
  assign inc_late     = evt_late & on_late;

  // software write decode at the window offsets
  assign wr_tx_ok    = reg_wr_i & (reg_addr_i == MACST_OFF_TX_OK);
  assign wr_oversize = reg_wr_i & (reg_addr_i == MACST_OFF_OVERSIZE);
  assign wr_mismatch = reg_wr_i & (reg_addr_i == MACST_OFF_LEN_MISMATCH);
  assign wr_late     = reg_wr_i & (reg_addr_i == MACST_OFF_LATE_COL);

  // transmit ok counter, wraps at 32 bits
  macst_stat_counter #(
    .WIDTH  (MACST_W_WIDE),
    .RSTVAL (MACST_RST_WIDE),
    .THRESH (MACST_THR_WIDE)
  ) u_tx_ok (
    .ref_clk_i    (ref_clk_i),
    .srst_i       (srst_i),
    .inc_i        (inc_tx_ok),
    .wr_i         (wr_tx_ok),
    .wr_data_i    (reg_wdata_i),
    .count_o      (cnt_tx_ok),
    .thresh_hit_o (hit_tx_ok)
  );

  // oversize counter, wraps at 16 bits
  macst_stat_counter #(
    .WIDTH  (MACST_W_NARROW),
    .RSTVAL (MACST_RST_NARROW),
    .THRESH (MACST_THR_NARROW)
  ) u_oversize (
    .ref_clk_i    (ref_clk_i),
    .srst_i       (srst_i),
    .inc_i        (inc_oversize),
    .wr_i         (wr_oversize),
    .wr_data_i    (reg_wdata_i[15:0]),
    .count_o      (cnt_oversize),
    .thresh_hit_o (hit_oversize)
  );

  // length mismatch counter, wraps at 16 bits, resets to zero
  macst_stat_counter #(
    .WIDTH  (MACST_W_NARROW),
    .RSTVAL (MACST_RST_NARROW),
    .THRESH (MACST_THR_NARROW)
  ) u_mismatch (
    .ref_clk_i    (ref_clk_i),
    .srst_i       (srst_i),
    .inc_i        (inc_mismatch),
    .wr_i         (wr_mismatch),
    .wr_data_i    (reg_wdata_i[15:0]),
    .count_o      (cnt_mismatch),
    .thresh_hit_o (hit_mismatch)
  );

  // late collision counter, wraps at 32 bits
  macst_stat_counter #(
    .WIDTH  (MACST_W_WIDE),
    .RSTVAL (MACST_RST_WIDE),
    .THRESH (MACST_THR_WIDE)
  ) u_late (
    .ref_clk_i    (ref_clk_i),
    .srst_i       (srst_i),
    .inc_i        (inc_late),
    .wr_i         (wr_late),
    .wr_data_i    (reg_wdata_i),
    .count_o      (cnt_late),
    .thresh_hit_o (hit_late)
  );

  // shared sticky statistics-update flag; a new hit beats a clear
  logic flag_ff;
  logic nxt_flag;

  assign any_hit = hit_tx_ok | hit_oversize | hit_mismatch | hit_late;

  always_comb begin
    nxt_flag = flag_ff;
    if (any_hit) begin
      nxt_flag = 1'b1;
    end else if (stats_flag_clr_i) begin
      nxt_flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign stats_threshold_flag_o = flag_ff;

  // registered read port, unmapped offsets read as zero
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;

  always_comb begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = reg_rd_i;
    if (reg_rd_i) begin
      case (reg_addr_i)
        MACST_OFF_TX_OK:        nxt_rdata = cnt_tx_ok;
        MACST_OFF_OVERSIZE:     nxt_rdata = {16'h0000, cnt_oversize};
        MACST_OFF_LEN_MISMATCH: nxt_rdata = {16'h0000, cnt_mismatch};
        MACST_OFF_LATE_COL:     nxt_rdata = cnt_late;
        default:                nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_ff  <= 32'h00000000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata_o  = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;

  // checks on counting, wrapping, gating, flag and software access
  a_txok_count_inc: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    tx_evt_i.frame_ok && on_tx_ok && !wr_tx_ok |=> cnt_tx_ok == $past(cnt_tx_ok) + 32'h1)
    else $error("transmit ok count did not step by one");

  a_txok_wrap_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    inc_tx_ok && !wr_tx_ok && cnt_tx_ok == 32'hFFFFFFFF |=> cnt_tx_ok == 32'h00000000)
    else $error("transmit ok count did not wrap to zero");

  a_txok_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    inc_tx_ok && !wr_tx_ok && cnt_tx_ok == 32'hBFFFFFFF |=> flag_ff && cnt_tx_ok == 32'hC0000000)
    else $error("transmit ok threshold did not raise the flag");

  a_global_off_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !stats_global_on_i && !reg_wr_i |=> $stable(cnt_tx_ok) && $stable(cnt_oversize)
      && $stable(cnt_mismatch) && $stable(cnt_late))
    else $error("a counter moved while statistics were off");

  a_oversize_count: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rx_evt_i.frame_done && rx_evt_i.frame_len > max_frame_length_reg_i && on_oversize
      && !wr_oversize |=> cnt_oversize == $past(cnt_oversize) + 16'h1)
    else $error("oversize frame not counted");

  a_oversize_wrap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    inc_oversize && !wr_oversize && cnt_oversize == 16'hFFFF |=> cnt_oversize == 16'h0000)
    else $error("oversize count did not wrap to zero");

  a_oversize_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    inc_oversize && !wr_oversize && cnt_oversize == 16'hBFFF |=> flag_ff)
    else $error("oversize threshold did not raise the flag");

  a_oversize_masked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    stats_mask_reg_i[MACST_MSK_OVERSIZE] && !wr_oversize |=> $stable(cnt_oversize))
    else $error("masked oversize count moved");

  a_mismatch_range: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rx_evt_i.frame_done && on_mismatch && !wr_mismatch
      && rx_evt_i.type_len >= MIN_UNPADDED && rx_evt_i.type_len <= MAX_CLIENT
      && rx_evt_i.type_len != rx_evt_i.data_octets
      |=> cnt_mismatch == $past(cnt_mismatch) + 16'h1)
    else $error("in-range length mismatch not counted");

  a_mismatch_short: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rx_evt_i.frame_done && on_mismatch && !wr_mismatch
      && rx_evt_i.type_len < MIN_UNPADDED && rx_evt_i.data_octets > MIN_UNPADDED
      |=> cnt_mismatch == $past(cnt_mismatch) + 16'h1)
    else $error("short length field mismatch not counted");

  a_mismatch_wrap: assert property (@(posedge ref_clk_i)
    (srst_i |=> cnt_mismatch == 16'h0000) and
    (inc_mismatch && !wr_mismatch && !srst_i && cnt_mismatch == 16'hFFFF
      |=> srst_i || cnt_mismatch == 16'h0000))
    else $error("mismatch count reset or wrap wrong");

  a_mismatch_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    inc_mismatch && !wr_mismatch && cnt_mismatch == 16'hBFFF |=> flag_ff)
    else $error("mismatch threshold did not raise the flag");

  a_mismatch_masked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    stats_mask_reg_i[MACST_MSK_LEN_MISMATCH] && !wr_mismatch |=> $stable(cnt_mismatch))
    else $error("masked mismatch count moved");

  a_late_count: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    tx_evt_i.collision && on_late && !wr_late
      |=> cnt_late == $past(cnt_late) + {31'h0, $past(tx_evt_i.octet_pos) > SLOT_OCTETS})
    else $error("late collision count wrong");

  a_late_wrap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    inc_late && !wr_late && cnt_late == 32'hFFFFFFFF |=> cnt_late == 32'h00000000)
    else $error("late collision count did not wrap");

  a_late_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    inc_late && !wr_late && cnt_late == 32'hBFFFFFFF |=> flag_ff)
    else $error("late collision threshold did not raise the flag");

  a_late_masked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    stats_mask_reg_i[MACST_MSK_LATE_COL] && !wr_late |=> $stable(cnt_late))
    else $error("masked late collision count moved");

  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    flag_ff && !stats_flag_clr_i |=> flag_ff)
    else $error("statistics flag dropped without a clear");

  a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    stats_flag_clr_i && !any_hit |=> !flag_ff)
    else $error("statistics flag not cleared");

  // the read samples the count before any increment taken in the read cycle
  a_write_replace: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_tx_ok ##1 (reg_rd_i && reg_addr_i == MACST_OFF_TX_OK && !reg_wr_i)
      |=> reg_rvalid_o
        && reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("written count not returned on read");

endmodule

//--- rtl/macst_stat_counter.sv
// one wrapping statistics counter with software load and threshold detect
`timescale 1ns/1ps

module macst_stat_counter #(
  parameter int unsigned        WIDTH  = 16,
  parameter logic [WIDTH-1:0]   RSTVAL = '0,
  parameter logic [WIDTH-1:0]   THRESH = '1
) (
  input  logic             ref_clk_i,
  input  logic             srst_i,
  input  logic             inc_i,
  input  logic             wr_i,
  input  logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] count_o,
  output logic             thresh_hit_o
);

  // refuse widths the counter cannot serve
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("macst_stat_counter: WIDTH must lie in 2..32");
  end

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;

  // software write replaces the count, else count up with natural wrap
  always_comb begin
    nxt_count = count_ff;
    if (wr_i) begin
      nxt_count = wr_data_i;
    end else if (inc_i) begin
      nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      count_ff <= RSTVAL;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // threshold is reached by counting, not by a software load
  assign thresh_hit_o = inc_i & ~wr_i & (nxt_count == THRESH);
  assign count_o      = count_ff;

endmodule

//--- testbench/macst_err_stats_tb.sv
// self-checking bench for the mac error statistics counters
`timescale 1ns/1ps

`define CHK(g, e) check_val(32'(g), 32'(e))

module testbench
  import macst_pkg::*;
;
  localparam logic [15:0] MAXLEN = 16'h05EE;

  logic                   ref_clk_i;
  logic                   srst_i;
  logic                   stats_global_on_i;
  logic [MACST_MSK_W-1:0] stats_mask_reg_i;
  logic [15:0]            max_frame_length_reg_i;
  macst_tx_evt_t          tx_evt_i;
  macst_rx_evt_t          rx_evt_i;
  logic [7:0]             reg_addr_i;
  logic                   reg_wr_i;
  logic [31:0]            reg_wdata_i;
  logic                   reg_rd_i;
  logic [31:0]            reg_rdata_o;
  logic                   reg_rvalid_o;
  logic                   stats_flag_clr_i;
  logic                   stats_threshold_flag_o;
  int                     n_fail;
  int                     n_compared;
  logic [7:0]             offs [4];

  macst_err_stats macst_err_stats_inst (
    .ref_clk_i              (ref_clk_i),
    .srst_i                 (srst_i),
    .stats_global_on_i      (stats_global_on_i),
    .stats_mask_reg_i       (stats_mask_reg_i),
    .max_frame_length_reg_i (max_frame_length_reg_i),
    .tx_evt_i               (tx_evt_i),
    .rx_evt_i               (rx_evt_i),
    .reg_addr_i             (reg_addr_i),
    .reg_wr_i               (reg_wr_i),
    .reg_wdata_i            (reg_wdata_i),
    .reg_rd_i               (reg_rd_i),
    .reg_rdata_o            (reg_rdata_o),
    .reg_rvalid_o           (reg_rvalid_o),
    .stats_flag_clr_i       (stats_flag_clr_i),
    .stats_threshold_flag_o (stats_threshold_flag_o)
  );

  // 40 MHz clock
  always #12.5 ref_clk_i = ~ref_clk_i;

  // verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // all tasks enter and leave just after a falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i    = 1'b0;
    reg_wdata_i = ~d;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    int i;
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    i = 0;
    while (reg_rvalid_o !== 1'b1 && i < 4) begin
      @(negedge ref_clk_i);
      i++;
    end
    if (i == 4) begin
      n_fail++;
      $display("unexpected at %0t: no read valid, got %h expected %h", $time, 1'b0, 1'b1);
      close_out();
    end else begin
      `CHK(reg_rdata_o, e);
      // idle cycle so a following read never re-raises the strobe in this step
      @(negedge ref_clk_i);
    end
  endtask

  // one event pulse: 0 tx ok, 1 rx length a, 2 rx type_len a data b, 3 collision at a
  task automatic fire(input int k, input logic [15:0] a, input logic [15:0] b);
    // idle cycle so back to back pulses never re-raise in the lowering step
    @(negedge ref_clk_i);
    tx_evt_i.frame_ok       = (k == 0);
    tx_evt_i.collision      = (k == 3);
    tx_evt_i.octet_pos      = a;
    rx_evt_i.frame_done     = (k == 1 || k == 2);
    rx_evt_i.frame_len      = (k == 1) ? a : 16'h0040;
    rx_evt_i.type_len       = (k == 2) ? a : 16'h0800;
    rx_evt_i.data_octets    = (k == 2) ? b : 16'h0032;
    @(negedge ref_clk_i);
    tx_evt_i.frame_ok   = 1'b0;
    tx_evt_i.collision  = 1'b0;
    rx_evt_i.frame_done = 1'b0;
  endtask

  task automatic clr_flag();
    stats_flag_clr_i = 1'b1;
    @(negedge ref_clk_i);
    stats_flag_clr_i = 1'b0;
  endtask

  // step into the threshold, then wrap from the top value
  task automatic thr_wrap(input int k, input logic [15:0] a, input logic [15:0] b);
    logic [31:0] thr;
    logic [31:0] top;
    thr = (k == 0 || k == 3) ? MACST_THR_WIDE : {16'h0000, MACST_THR_NARROW};
    top = (k == 0 || k == 3) ? 32'hFFFFFFFF : 32'h0000FFFF;
    wr(offs[k], thr - 32'h1);
    clr_flag();
    fire(k, a, b);
    rd_chk(offs[k], thr);
    `CHK(stats_threshold_flag_o, 1'b1);
    clr_flag();
    `CHK(stats_threshold_flag_o, 1'b0);
    wr(offs[k], top);
    fire(k, a, b);
    rd_chk(offs[k], 32'h0);
    `CHK(stats_threshold_flag_o, 1'b0);
  endtask

  // global enable off, then own mask bit set, then both allowing
  task automatic en_chk(input int k, input logic [15:0] a, input logic [15:0] b);
    wr(offs[k], 32'h10);
    stats_global_on_i = 1'b0;
    fire(k, a, b);
    rd_chk(offs[k], 32'h10);
    stats_global_on_i = 1'b1;
    stats_mask_reg_i[k] = 1'b1;
    fire(k, a, b);
    rd_chk(offs[k], 32'h10);
    stats_mask_reg_i = '0;
    fire(k, a, b);
    rd_chk(offs[k], 32'h11);
  endtask

  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      rd_chk(offs[k], 32'h0);
    end
    wr(8'h00, 32'h1234);
    rd_chk(8'h00, 32'h0);
    `CHK(stats_threshold_flag_o, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_tx();
    wr(MACST_OFF_TX_OK, 32'h5);
    rd_chk(MACST_OFF_TX_OK, 32'h5);
    fire(0, 16'h0, 16'h0);
    fire(0, 16'h0, 16'h0);
    rd_chk(MACST_OFF_TX_OK, 32'h7);
    thr_wrap(0, 16'h0, 16'h0);
    en_chk(0, 16'h0, 16'h0);
    $display("test tx ok done");
  endtask

  task automatic t_over();
    wr(MACST_OFF_OVERSIZE, 32'hFFFF0000);
    rd_chk(MACST_OFF_OVERSIZE, 32'h0);
    fire(1, MAXLEN + 16'h1, 16'h0);
    fire(1, MAXLEN, 16'h0);
    rd_chk(MACST_OFF_OVERSIZE, 32'h1);
    thr_wrap(1, MAXLEN + 16'h1, 16'h0);
    en_chk(1, MAXLEN + 16'h1, 16'h0);
    $display("test oversize done");
  endtask

  task automatic t_mism();
    logic [15:0] tl [8] = '{16'd100, 16'd100, 16'd46, 16'd46, 16'd1500, 16'd1501, 16'd10, 16'd10};
    logic [15:0] dn [8] = '{16'd99, 16'd100, 16'd47, 16'd46, 16'd1499, 16'd10, 16'd47, 16'd46};
    logic [31:0] ex [8] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h3, 32'h3, 32'h4, 32'h4};
    wr(MACST_OFF_LEN_MISMATCH, 32'h0);
    for (int i = 0; i < 8; i++) begin
      fire(2, tl[i], dn[i]);
      rd_chk(MACST_OFF_LEN_MISMATCH, ex[i]);
    end
    thr_wrap(2, 16'd100, 16'd99);
    en_chk(2, 16'd100, 16'd99);
    $display("test length mismatch done");
  endtask

  task automatic t_late();
    wr(MACST_OFF_LATE_COL, 32'h0);
    fire(3, 16'd64, 16'h0);
    fire(3, 16'd65, 16'h0);
    fire(3, 16'd1000, 16'h0);
    rd_chk(MACST_OFF_LATE_COL, 32'h2);
    thr_wrap(3, 16'd65, 16'h0);
    en_chk(3, 16'd65, 16'h0);
    $display("test late collision done");
  endtask

  task automatic t_flag();
    wr(MACST_OFF_TX_OK, MACST_THR_WIDE - 32'h1);
    fire(0, 16'h0, 16'h0);
    fire(0, 16'h0, 16'h0);
    repeat (3) @(negedge ref_clk_i);
    `CHK(stats_threshold_flag_o, 1'b1);
    rd_chk(MACST_OFF_TX_OK, MACST_THR_WIDE + 32'h1);
    clr_flag();
    wr(MACST_OFF_OVERSIZE, {16'h0000, MACST_THR_NARROW - 16'h1});
    stats_flag_clr_i = 1'b1;
    fire(1, MAXLEN + 16'h1, 16'h0);
    stats_flag_clr_i = 1'b0;
    `CHK(stats_threshold_flag_o, 1'b1);
    clr_flag();
    wr(MACST_OFF_LATE_COL, MACST_THR_WIDE);
    @(negedge ref_clk_i);
    `CHK(stats_threshold_flag_o, 1'b0);
    $display("test shared flag done");
  endtask

  initial begin
    offs = '{MACST_OFF_TX_OK, MACST_OFF_OVERSIZE, MACST_OFF_LEN_MISMATCH, MACST_OFF_LATE_COL};
    n_fail = 0;
    n_compared = 0;
    ref_clk_i = 1'b0;
    srst_i = 1'b1;
    stats_global_on_i = 1'b1;
    stats_mask_reg_i = '0;
    max_frame_length_reg_i = MAXLEN;
    tx_evt_i = '0;
    rx_evt_i = '0;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 32'h0;
    reg_rd_i = 1'b0;
    stats_flag_clr_i = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    srst_i = 1'b0;
    t_reset();
    t_tx();
    t_over();
    t_mism();
    t_late();
    t_flag();
    close_out();
  end
endmodule
